/* hw/rtd_meter_input_registers.sv */
// Contract
// - channel 6 temperature: signed 16-bit, 0.01 C units, -20000..32767.
// - 32-bit seconds-since-power-up counter across two registers.
// - 32-bit counter of conversions on all channels across two registers.
// - status bit 0 set whenever any error flag is set.
// - open circuit on channels 1..6 flagged in status bits 4..9.
// - short: ch1 bit 10, ch3..5 bits 12..14, ch6 bit 15; bit 11 zero.
// - status bit 16 set on configuration storage failure.
// - status bit 17 set when supply voltage is too low.
// - status bit 18 set when no addressed traffic within timeout.
// - status bit 19 set while testing mode is active.
// - status map spans two registers; only low 20 bits can be set.
// - pin register: bits 0-4 switch, 5-8 bootstrap, 9 pushbutton.
// - analog reference voltage reported in whole millivolts.
// - supply voltage reported in whole millivolts.
// - channel 1 and 2 temperatures as float32 over register pairs.
// - float temperatures are whole degrees Celsius, -200..600; the code stores them as given, with no clamp.
`timescale 1ns/1ps

module rtd_meter_input_registers
	import rtd_regs_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_SECOND,
	parameter int unsigned TIMEOUT_SEC = BUS_TIMEOUT_S,
	parameter int unsigned LOW_SUPPLY_MV = SUPPLY_MIN_MV
) (
	input wire logic clk,
	input wire logic rst_n,
	// register access from the protocol engine
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_index,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_error,
	// bus activity: one pulse per frame addressed to this unit
	input wire logic frame_seen,
	// measurement chain results
	input wire logic temp6_valid,
	input wire logic signed [15:0] temp6_centi,
	input wire logic temp1_float_valid,
	input wire logic [31:0] temp1_float,
	input wire logic temp2_float_valid,
	input wire logic [31:0] temp2_float,
	input wire logic conversion_done,
	input wire logic [NUM_CH-1:0] sensor_open,
	input wire logic [NUM_CH-1:0] sensor_short,
	input wire logic flash_fail,
	input wire logic test_mode,
	input wire logic volt_valid,
	input wire logic [15:0] analog_ref_mv,
	input wire logic [15:0] supply_mv,
	// asynchronous pins
	input wire logic [ADDR_SW_W-1:0] addr_switch_pins,
	input wire logic [BOOT_W-1:0] bootstrap_pins,
	input wire logic button_pin
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam logic [31:0] SEC_LAST = 32'(CYCLES_PER_SEC - 1);
	localparam logic [31:0] TIMEOUT_LAST = 32'(TIMEOUT_SEC);
	localparam logic [15:0] LOW_MV = 16'(LOW_SUPPLY_MV);
	// low half of a pair sits one index above its high half
	localparam logic [15:0] LOW_HALF = 16'h0001;

	logic [31:0] tick_cnt_q;
	logic sec_tick_q;
	logic [31:0] uptime_q;
	logic [31:0] conv_cnt_q;
	logic [31:0] idle_sec_q;
	logic bus_timeout_q;
	logic signed [15:0] temp6_q;
	logic [31:0] temp1_q;
	logic [31:0] temp2_q;
	logic [15:0] aref_q;
	logic [15:0] supply_q;
	logic low_supply_q;
	logic [FLAG_WIDTH-1:0] flags_q;
	logic [FLAG_WIDTH-1:0] flags_d;
	logic [FLAG_WIDTH-1:0] chan_bits [NUM_CH];
	logic [PIN_W-1:0] pins_sync;
	logic [PIN_W-1:0] pins_q;
	logic [31:0] pair_live [NUM_PAIRS];
	logic [15:0] shadow_q [NUM_PAIRS];
	logic [15:0] rdata_d;
	logic hit_d;

	// ****************************************************************
	// pin sampling
	// ****************************************************************
	pin_sync #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({button_pin, bootstrap_pins, addr_switch_pins}),
		.sync_out(pins_sync)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_q <= '0;
		end else begin
			pins_q <= pins_sync;
		end
	end

	// ****************************************************************
	// one-second time base
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			sec_tick_q <= 1'b0;
		end else if (tick_cnt_q >= SEC_LAST) begin
			tick_cnt_q <= '0;
			sec_tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			sec_tick_q <= 1'b0;
		end
	end

	// reset stands in for power-up here; wraps after about 136 years
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uptime_q <= '0;
		end else if (sec_tick_q) begin
			uptime_q <= uptime_q + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// conversion counter
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_q <= '0;
		end else if (conversion_done) begin
			conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// bus silence watchdog
	// ****************************************************************
	// a frame in the same cycle as a tick wins, so silence restarts at 0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_sec_q <= '0;
			bus_timeout_q <= 1'b0;
		end else if (frame_seen) begin
			idle_sec_q <= '0;
			bus_timeout_q <= 1'b0;
		end else if (sec_tick_q && idle_sec_q < TIMEOUT_LAST) begin
			idle_sec_q <= idle_sec_q + 32'h0000_0001;
		end else if (idle_sec_q >= TIMEOUT_LAST) begin
			bus_timeout_q <= 1'b1;
		end
	end

	// ****************************************************************
	// measurement holding registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp6_q <= '0;
		end else if (temp6_valid) begin
			// clamp keeps the published range even on a bad sample
			if (temp6_centi < TEMP_FIXED_MIN) begin
				temp6_q <= TEMP_FIXED_MIN;
			end else begin
				temp6_q <= temp6_centi;
			end
		end
	end

	// floats arrive already scaled to whole degrees
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp1_q <= '0;
			temp2_q <= '0;
		end else begin
			if (temp1_float_valid) begin
				temp1_q <= temp1_float;
			end
			if (temp2_float_valid) begin
				temp2_q <= temp2_float;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aref_q <= '0;
			supply_q <= '0;
			low_supply_q <= 1'b0;
		end else if (volt_valid) begin
			aref_q <= analog_ref_mv;
			supply_q <= supply_mv;
			low_supply_q <= (supply_mv < LOW_MV);
		end
	end

	// ****************************************************************
	// per-channel sensor faults
	// ****************************************************************
	for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
		localparam int OPEN_POS = BIT_OPEN_CH1 + c;
		localparam int SHORT_POS = BIT_SHORT_CH1 + c;
		// channel 2 short has no bit of its own, so it shows in bit 0 only
		localparam bit HAS_SHORT = (SHORT_POS != BIT_SHORT_CH3 - 1);
		logic open_hit;
		logic short_hit;
		assign open_hit = sensor_open[c];
		assign short_hit = sensor_short[c] && HAS_SHORT;
		assign chan_bits[c] = (FLAG_WIDTH'(open_hit) << OPEN_POS) |
			(FLAG_WIDTH'(short_hit) << SHORT_POS);
	end

	// ****************************************************************
	// status map
	// ****************************************************************
	always_comb begin
		flags_d = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			flags_d = flags_d | chan_bits[c];
		end
		flags_d[BIT_FLASH] = flash_fail;
		flags_d[BIT_LOW_SUPPLY] = low_supply_q;
		flags_d[BIT_BUS_TIMEOUT] = bus_timeout_q;
		flags_d[BIT_TEST_MODE] = test_mode;
		// test mode is a state, not an error, so bit 0 leaves it out
		flags_d[BIT_GENERIC] = (|sensor_open) | (|sensor_short) |
			flash_fail | low_supply_q | bus_timeout_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_comb begin
		pair_live[PAIR_UPTIME] = uptime_q;
		pair_live[PAIR_CONV] = conv_cnt_q;
		pair_live[PAIR_FLAGS] = 32'(flags_q);
		pair_live[PAIR_TEMP1] = temp1_q;
		pair_live[PAIR_TEMP2] = temp2_q;
	end

	// reading the high word freezes the low word for the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PAIRS; p++) begin
				shadow_q[p] <= '0;
			end
		end else if (reg_rd) begin
			unique case (reg_index)
				IDX_UPTIME_SECONDS: begin
					shadow_q[PAIR_UPTIME] <= uptime_q[15:0];
				end
				IDX_CONVERSION_COUNT: begin
					shadow_q[PAIR_CONV] <= conv_cnt_q[15:0];
				end
				IDX_FAULT_FLAGS: begin
					shadow_q[PAIR_FLAGS] <= pair_live[PAIR_FLAGS][15:0];
				end
				IDX_TEMP_CH1_FLOAT: begin
					shadow_q[PAIR_TEMP1] <= temp1_q[15:0];
				end
				IDX_TEMP_CH2_FLOAT: begin
					shadow_q[PAIR_TEMP2] <= temp2_q[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_d = '0;
		hit_d = 1'b1;
		unique case (reg_index)
			IDX_TEMP_CH6_FIXED: rdata_d = temp6_q;
			IDX_UPTIME_SECONDS: rdata_d = uptime_q[31:16];
			IDX_UPTIME_SECONDS + LOW_HALF: rdata_d = shadow_q[PAIR_UPTIME];
			IDX_CONVERSION_COUNT: rdata_d = conv_cnt_q[31:16];
			IDX_CONVERSION_COUNT + LOW_HALF: rdata_d = shadow_q[PAIR_CONV];
			IDX_FAULT_FLAGS: rdata_d = pair_live[PAIR_FLAGS][31:16];
			IDX_FAULT_FLAGS + LOW_HALF: rdata_d = shadow_q[PAIR_FLAGS];
			IDX_PIN_INPUTS: rdata_d = 16'(pins_q);
			IDX_ANALOG_REF_MILLIVOLTS: rdata_d = aref_q;
			IDX_SUPPLY_MILLIVOLTS: rdata_d = supply_q;
			IDX_TEMP_CH1_FLOAT: rdata_d = temp1_q[31:16];
			IDX_TEMP_CH1_FLOAT + LOW_HALF: rdata_d = shadow_q[PAIR_TEMP1];
			IDX_TEMP_CH2_FLOAT: rdata_d = temp2_q[31:16];
			IDX_TEMP_CH2_FLOAT + LOW_HALF: rdata_d = shadow_q[PAIR_TEMP2];
			default: hit_d = 1'b0;
		endcase
	end

	// ****************************************************************
	// answer to each request
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd || reg_wr;
		end
	end

	// writes store nothing and are answered with an error
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_error <= 1'b0;
		end else begin
			reg_error <= reg_wr || (reg_rd && !hit_d);
		end
	end

	// data drops to zero between answers so a stale word is never taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd && hit_d) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

/* hw/rtd_regs_pkg.sv */
package rtd_regs_pkg;

	// ****************************************************************
	// register indices (one index per 16-bit register)
	// ****************************************************************
	localparam logic [15:0] IDX_TEMP_CH6_FIXED = 16'h0005;
	localparam logic [15:0] IDX_UPTIME_SECONDS = 16'h0006;
	localparam logic [15:0] IDX_CONVERSION_COUNT = 16'h0008;
	localparam logic [15:0] IDX_FAULT_FLAGS = 16'h000A;
	localparam logic [15:0] IDX_PIN_INPUTS = 16'h000C;
	localparam logic [15:0] IDX_ANALOG_REF_MILLIVOLTS = 16'h000D;
	localparam logic [15:0] IDX_SUPPLY_MILLIVOLTS = 16'h000E;
	localparam logic [15:0] IDX_TEMP_CH1_FLOAT = 16'h000F;
	localparam logic [15:0] IDX_TEMP_CH2_FLOAT = 16'h0011;

	// ****************************************************************
	// 32-bit pairs, shadowed for coherent reads
	// ****************************************************************
	localparam int NUM_PAIRS = 5;
	localparam int PAIR_UPTIME = 0;
	localparam int PAIR_CONV = 1;
	localparam int PAIR_FLAGS = 2;
	localparam int PAIR_TEMP1 = 3;
	localparam int PAIR_TEMP2 = 4;

	// ****************************************************************
	// fault_flags layout
	// ****************************************************************
	localparam int NUM_CH = 6;
	localparam int FLAG_WIDTH = 20;
	localparam int BIT_GENERIC = 0;
	localparam int BIT_OPEN_CH1 = 4;
	localparam int BIT_SHORT_CH1 = 10;
	localparam int BIT_SHORT_CH3 = 12;
	localparam int BIT_SHORT_CH6 = 15;
	localparam int BIT_FLASH = 16;
	localparam int BIT_LOW_SUPPLY = 17;
	localparam int BIT_BUS_TIMEOUT = 18;
	localparam int BIT_TEST_MODE = 19;

	// ****************************************************************
	// pin_inputs layout
	// ****************************************************************
	localparam int ADDR_SW_W = 5;
	localparam int BOOT_W = 4;
	localparam int PIN_W = ADDR_SW_W + BOOT_W + 1;
	localparam int BIT_BUTTON = 9;

	// ****************************************************************
	// value limits and timing
	// ****************************************************************
	localparam logic signed [15:0] TEMP_FIXED_MIN = -16'sd20000;
	localparam int SUPPLY_MIN_MV = 5000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SECOND_NS = 1000000000;
	localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
	localparam int BUS_TIMEOUT_S = 10;

endpackage

/* hw/pin_sync.sv */
`timescale 1ns/1ps

// ****************************************************************
// two-stage synchroniser for asynchronous pins
// ****************************************************************
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

/* tb/rtd_regs_props.sv */
`timescale 1ns/1ps

// ****
// port checks
// ****
module rtd_regs_props
	import rtd_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_index,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic mapped;
	assign mapped = reg_index inside {[IDX_TEMP_CH6_FIXED:16'h0012]};
	property p_ans; (reg_rd || reg_wr) |=> reg_rvalid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_idle;
		!(reg_rd || reg_wr) |=> !reg_rvalid && reg_rdata == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_wr; reg_wr |=> reg_error && reg_rdata == 16'h0000; endproperty
	a_wr: assert property (p_wr) else $error("write accepted");
	property p_map; reg_rd && mapped |=> !reg_error; endproperty
	a_map: assert property (p_map) else $error("mapped read refused");
	property p_unmap;
		reg_rd && !mapped |=> reg_error && reg_rdata == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_err;
		!(reg_wr || (reg_rd && !mapped)) |=> !reg_error;
	endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_hi;
		reg_rd && reg_index == IDX_FAULT_FLAGS |=> reg_rdata[15:4] == 12'h000;
	endproperty
	a_hi: assert property (p_hi) else $error("flag above bit 19");
	property p_pins;
		reg_rd && reg_index == IDX_PIN_INPUTS |=> reg_rdata[15:10] == 6'h00;
	endproperty
	a_pins: assert property (p_pins) else $error("pin bits high");
	property p_t6;
		reg_rd && reg_index == IDX_TEMP_CH6_FIXED
			|=> $signed(reg_rdata) >= TEMP_FIXED_MIN;
	endproperty
	a_t6: assert property (p_t6) else $error("temp below floor");
	property p_lo;
		reg_rd && reg_index == 16'h000B
			|=> reg_rdata[11] == 1'b0 && reg_rdata[3:1] == 3'h0;
	endproperty
	a_lo: assert property (p_lo) else $error("undefined flag set");
endmodule

bind rtd_meter_input_registers rtd_regs_props i_props (.clk, .rst_n,
	.reg_rd, .reg_wr, .reg_index, .reg_rdata, .reg_rvalid, .reg_error);

/* tb/rtu_master_model.sv */
`timescale 1ns/1ps

module rtu_master_model (
	input wire logic clk,
	output logic reg_rd,
	output logic reg_wr,
	output logic [15:0] reg_index,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_error
);
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_index = 16'hFFFF;
	end
	// index inverted on release so a stale value is never read as held
	task automatic xfer(input logic wr, input logic [15:0] idx,
		output logic [17:0] ans);
		@(posedge clk);
		reg_rd <= !wr;
		reg_wr <= wr;
		reg_index <= idx;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		reg_index <= ~idx;
		#1;
		ans = {reg_rvalid, reg_error, reg_rdata};
	endtask
endmodule

/* tb/tb_rtd_meter_input_registers.sv */
`timescale 1ns/1ps

module tb_rtd_meter_input_registers;
	import rtd_regs_pkg::*;
	localparam int CPS = 20;
	logic clk, rst_n, frame_seen, temp6_valid, temp1_float_valid;
	logic temp2_float_valid, conversion_done, flash_fail, test_mode;
	logic volt_valid, button_pin, reg_rd, reg_wr, reg_rvalid, reg_error;
	logic [15:0] reg_index, reg_rdata, analog_ref_mv, supply_mv, up0;
	logic signed [15:0] temp6_centi;
	logic [31:0] temp1_float, temp2_float;
	logic [NUM_CH-1:0] sensor_open, sensor_short;
	logic [ADDR_SW_W-1:0] addr_switch_pins;
	logic [BOOT_W-1:0] bootstrap_pins;
	logic [17:0] ans;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;

	// short second and timeout keep the run brief
	rtd_meter_input_registers #(.CYCLES_PER_SEC(CPS), .TIMEOUT_SEC(3),
		.LOW_SUPPLY_MV(5000)) i_dut (.clk, .rst_n, .reg_rd, .reg_wr,
		.reg_index, .reg_rdata, .reg_rvalid, .reg_error, .frame_seen,
		.temp6_valid, .temp6_centi, .temp1_float_valid, .temp1_float,
		.temp2_float_valid, .temp2_float, .conversion_done, .sensor_open,
		.sensor_short, .flash_fail, .test_mode, .volt_valid,
		.analog_ref_mv, .supply_mv, .addr_switch_pins, .bootstrap_pins,
		.button_pin);
	rtu_master_model i_master (.clk, .reg_rd, .reg_wr, .reg_index,
		.reg_rdata, .reg_rvalid, .reg_error);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****
	// tasks
	// ****
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
		i_master.xfer(1'b0, idx, ans);
		chk(ans, {2'b10, exp});
	endtask
	task automatic refused(input logic wr, input logic [15:0] idx);
		i_master.xfer(wr, idx, ans);
		chk(ans, 18'h30000);
	endtask
	task automatic flags(input logic [31:0] exp);
		@(posedge clk);
		frame_seen <= 1'b1;
		@(posedge clk);
		frame_seen <= 1'b0;
		rd(IDX_FAULT_FLAGS, exp[31:16]);
		rd(16'h000B, exp[15:0]);
	endtask
	task automatic meas(input logic [15:0] t6, input logic [31:0] f1,
		input logic [31:0] f2, input logic [15:0] s);
		@(posedge clk);
		{temp6_valid, temp1_float_valid, temp2_float_valid} <= 3'h7;
		volt_valid <= 1'b1;
		temp6_centi <= t6;
		temp1_float <= f1;
		temp2_float <= f2;
		analog_ref_mv <= 16'h0CE4;
		supply_mv <= s;
		@(posedge clk);
		{temp6_valid, temp1_float_valid, temp2_float_valid} <= 3'h0;
		volt_valid <= 1'b0;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			conclude();
		end
	end

	// ****
	// sequence
	// ****
	initial begin
		rst_n = 1'b0;
		{frame_seen, temp6_valid, temp1_float_valid, temp2_float_valid,
			conversion_done, flash_fail, test_mode, volt_valid, button_pin,
			analog_ref_mv, supply_mv, temp6_centi, temp1_float, temp2_float,
			sensor_open, sensor_short, addr_switch_pins, bootstrap_pins} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(IDX_CONVERSION_COUNT, 16'h0000);
		@(posedge clk);
		conversion_done <= 1'b1;
		repeat (3) @(posedge clk);
		conversion_done <= 1'b0;
		rd(IDX_CONVERSION_COUNT, 16'h0000);
		rd(16'h0009, 16'h0003);
		meas(16'h04D2, 32'h42C8_1234, 32'h43FA_8000, 16'h2EE0);
		rd(IDX_TEMP_CH6_FIXED, 16'h04D2);
		rd(IDX_TEMP_CH2_FLOAT, 16'h43FA);
		rd(16'h0012, 16'h8000);
		rd(IDX_ANALOG_REF_MILLIVOLTS, 16'h0CE4);
		rd(IDX_SUPPLY_MILLIVOLTS, 16'h2EE0);
		rd(IDX_TEMP_CH1_FLOAT, 16'h42C8);
		// low half must come from the snapshot, not the new value
		meas(16'h8AD0, 32'h4416_ABCD, 32'hC348_0000, 16'h0FA0);
		rd(16'h0010, 16'h1234);
		rd(IDX_TEMP_CH6_FIXED, 16'hB1E0);
		flags(32'h0002_0001);
		meas(16'h0000, 32'h0, 32'h0, 16'h2EE0);
		for (int i = 0; i < NUM_CH; i++) begin
			@(posedge clk);
			sensor_open <= 6'h01 << i;
			flags((32'h1 << (i + 4)) | 32'h1);
			@(posedge clk);
			sensor_open <= 6'h00;
			sensor_short <= 6'h01 << i;
			flags((i == 1 ? 32'h0 : 32'h1 << (i + 10)) | 32'h1);
			@(posedge clk);
			sensor_short <= 6'h00;
		end
		@(posedge clk);
		flash_fail <= 1'b1;
		flags(32'h0001_0001);
		@(posedge clk);
		flash_fail <= 1'b0;
		test_mode <= 1'b1;
		flags(32'h0008_0000);
		@(posedge clk);
		test_mode <= 1'b0;
		flags(32'h0000_0000);
		repeat (70) @(posedge clk);
		rd(IDX_FAULT_FLAGS, 16'h0004);
		rd(16'h000B, 16'h0001);
		flags(32'h0000_0000);
		@(posedge clk);
		addr_switch_pins <= 5'h15;
		bootstrap_pins <= 4'hA;
		button_pin <= 1'b1;
		repeat (4) @(posedge clk);
		rd(IDX_PIN_INPUTS, 16'h0355);
		refused(1'b1, IDX_PIN_INPUTS);
		rd(IDX_PIN_INPUTS, 16'h0355);
		refused(1'b0, 16'h0004);
		refused(1'b0, 16'h0013);
		rd(IDX_UPTIME_SECONDS, 16'h0000);
		i_master.xfer(1'b0, 16'h0007, ans);
		up0 = ans[15:0];
		// next high-half read lands exactly two seconds later
		repeat (2 * CPS - 4) @(posedge clk);
		rd(IDX_UPTIME_SECONDS, 16'h0000);
		rd(16'h0007, up0 + 16'h0002);
		conclude();
	end
endmodule
